// [design/btn_filter.sv]
// Pin synchroniser and debounce filter for button and power inputs
`timescale 1ns/10ps
`default_nettype none
module btn_filter #(
  parameter int W = 5,
  parameter logic [31:0] HOLD = 32'h0000_0010,
  parameter logic [W-1:0] IDLE = '1
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Pins and filtered levels
  input wire logic [W-1:0] raw,
  output logic [W-1:0] level
);
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] lvl;
    logic [W-1:0][31:0] cnt;
  } filt_s;

  filt_s q;
  filt_s next_q;

  always_comb begin
    next_q = q;
    next_q.s1 = raw;
    next_q.s2 = q.s1;
    next_q.s3 = q.s2;
    for (int i = 0; i < W; i++) begin
      if (q.s2[i] != q.s3[i] || q.s3[i] == q.lvl[i]) begin
        next_q.cnt[i] = '0;
      end else if (q.cnt[i] >= HOLD - 32'h0000_0001) begin
        next_q.lvl[i] = q.s3[i];
        next_q.cnt[i] = '0;
      end else begin
        next_q.cnt[i] = q.cnt[i] + 32'h0000_0001;
      end
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.s1 <= IDLE;
      q.s2 <= IDLE;
      q.s3 <= IDLE;
      q.lvl <= IDLE;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign level = q.lvl;
endmodule
`default_nettype wire

// [design/cfg_menu_pkg.sv]
// Shared constants, register map and types of the front-panel menu
package cfg_menu_pkg;
  // Timing
  localparam int unsigned CLK_HZ = 40_000_000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned CODE_TO_S = 10;
  localparam int unsigned MENU_TO_S = 60;
  localparam int unsigned DEB_MS = 10;
  localparam logic [63:0] CODE_TO_CYC = 64'(CODE_TO_S) * 64'(CLK_HZ);
  localparam logic [63:0] MENU_TO_CYC = 64'(MENU_TO_S) * 64'(CLK_HZ);
  localparam logic [63:0] DEB_CYC = 64'(CLK_HZ) / 64'(MS_PER_S) * 64'(DEB_MS);

  // Register byte offsets
  localparam logic [7:0] REG_STATUS = 8'h00;
  localparam logic [7:0] REG_IRQ_STAT = 8'h04;
  localparam logic [7:0] REG_IRQ_MASK = 8'h08;
  localparam logic [7:0] REG_ACODE = 8'h0C;
  localparam logic [7:0] REG_CFG0 = 8'h10;
  localparam logic [7:0] REG_QCODE = 8'h14;
  localparam logic [7:0] REG_CFG1 = 8'h18;
  localparam logic [7:0] REG_BAR = 8'h1C;
  localparam logic [7:0] REG_SCALE = 8'h20;
  localparam logic [7:0] REG_DEFAULTS = 8'h24;
  localparam logic [7:0] REG_MENU = 8'h28;
  localparam logic [7:0] REG_EDIT = 8'h2C;

  // Field positions
  localparam int F_ALM_EN = 8;
  localparam int F_GOOD = 16;
  localparam int F_NC = 17;
  localparam int F_LAST = 28;
  localparam int F_MAIN = 0;
  localparam int F_SUB = 4;
  localparam int F_MULTI = 8;
  localparam int F_OPTS = 16;
  localparam int F_DIGS = 20;
  localparam int S_HL = 8;
  localparam int S_SUB = 12;
  localparam int S_POS = 16;
  localparam int S_BUS = 20;
  localparam int S_FLASH = 21;

  // Buttons and events
  localparam int NB = 4;
  localparam int BTN_SEL = 0;
  localparam int BTN_ENT = 1;
  localparam int BTN_DN = 2;
  localparam int BTN_UP = 3;
  localparam int N_ALM = 6;
  localparam int N_IRQ = 6;
  localparam int IRQ_ENTER = 0;
  localparam int IRQ_BADCODE = 1;
  localparam int IRQ_TIMEOUT = 2;
  localparam int IRQ_COMMIT = 3;
  localparam int IRQ_EXIT = 4;
  localparam int IRQ_PWR = 5;
  localparam int CODE_DIGS = 4;

  // Reset and factory values
  localparam logic [15:0] DEF_CODE = 16'h0000;
  localparam logic [31:0] DEF_CFG0 = 32'h0732_647E;
  localparam logic [31:0] DEF_CFG1 = 32'h817F_0001;
  localparam logic [31:0] DEF_BAR = 32'h0064_0000;
  localparam logic [31:0] DEF_SCALE = 32'h0001_0000;
  localparam logic [31:0] DEF_MENU = 32'h0042_001B;
  localparam logic [4:0] IN_IDLE = 5'h1F;

  typedef enum logic [6:0] {
    ST_OPER = 7'h01,
    ST_CODE = 7'h02,
    ST_BAD = 7'h04,
    ST_MAIN = 7'h08,
    ST_SUB = 7'h10,
    ST_ADJ = 7'h20,
    ST_DIG = 7'h40
  } menu_e;
endpackage

// [design/front_panel_menu.sv]
// Front-panel configuration menu controller with Wishbone registers
`timescale 1ns/10ps
`default_nettype none
module front_panel_menu #(
  parameter logic [31:0] CODE_TO = 32'(cfg_menu_pkg::CODE_TO_CYC),
  parameter logic [31:0] MENU_TO = 32'(cfg_menu_pkg::MENU_TO_CYC),
  parameter logic [31:0] DEB_HOLD = 32'(cfg_menu_pkg::DEB_CYC)
) (
  // Clock, reset, enable
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  // Push buttons, active low: select, enter, down, up
  input wire logic [3:0] btn_n,
  // Fieldbus power and alarm sources
  input wire logic bus_power_ok,
  input wire logic [5:0] alarm_req,
  input wire logic data_good,
  // Alarm switch outputs, high means closed
  output logic [5:0] alarm_close,
  // Interrupt
  output logic irq,
  // Display state
  output logic [6:0] menu_state,
  output logic [3:0] highlight,
  output logic [3:0] sub_highlight,
  output logic [2:0] edit_pos,
  output logic [31:0] edit_value,
  output logic flash,
  output logic [3:0] screen_sel
);
  typedef struct packed {
    logic ack;
    logic [31:0] dat;
    cfg_menu_pkg::menu_e st;
    logic [3:0] hl;
    logic [3:0] sub_hl;
    logic [2:0] pos;
    logic [15:0] code;
    logic [31:0] val;
    logic [cfg_menu_pkg::NB-1:0] prev;
    logic armed;
    logic [3:0] screen;
    logic bus_ok;
    logic [cfg_menu_pkg::N_IRQ-1:0] irq_stat;
    logic [cfg_menu_pkg::N_IRQ-1:0] irq_mask;
    logic [15:0] acode;
    logic [15:0] qcode;
    logic [31:0] cfg0;
    logic [31:0] cfg1;
    logic [31:0] bar;
    logic [31:0] scale;
    logic [31:0] menu_cfg;
    logic [cfg_menu_pkg::N_ALM-1:0] alm;
    logic irq;
  } menu_s;

  menu_s q;
  menu_s next_q;
  logic [4:0] flt;
  logic tmo;
  logic kick;
  logic run;

  // Byte-lane merge of a write
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[8*i +: 8] = wd[8*i +: 8];
      end
    end
    return r;
  endfunction

  // Step one nibble of a value up or down, wrapping
  function automatic logic [31:0] step_nib(input logic [31:0] v, input logic [2:0] p,
                                           input logic up);
    logic [31:0] r;
    logic [3:0] n;
    r = v;
    n = v[4*p +: 4];
    n = up ? n + 4'h1 : n - 4'h1;
    r[4*p +: 4] = n;
    return r;
  endfunction

  // Step an index within 0..count-1, a count of zero meaning sixteen
  function automatic logic [3:0] wrap_step(input logic [3:0] idx, input logic [3:0] count,
                                           input logic up);
    logic [3:0] top;
    top = count - 4'h1;
    if (up) begin
      return (idx >= top) ? 4'h0 : idx + 4'h1;
    end
    return (idx == 4'h0 || idx > top) ? top : idx - 4'h1;
  endfunction

  // Position advance within a field of the given digit count
  function automatic logic [2:0] next_pos(input logic [2:0] p, input logic [3:0] digs);
    logic [3:0] n;
    n = {1'b0, p} + 4'h1;
    return (n >= digs) ? 3'h0 : n[2:0];
  endfunction

  // Button pins and bus power share one filter
  btn_filter #(
    .W(5),
    .HOLD(DEB_HOLD),
    .IDLE(cfg_menu_pkg::IN_IDLE)
  ) u_filter (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .raw({bus_power_ok, btn_n}),
    .level(flt)
  );

  assign run = (q.st != cfg_menu_pkg::ST_OPER);

  idle_timer u_timer (
    .clk_sys(clk_sys),
    .rst(rst),
    .ce(ce),
    .run(run),
    .kick(kick),
    .limit((q.st == cfg_menu_pkg::ST_CODE) ? CODE_TO : MENU_TO),
    .expired(tmo)
  );

  always_comb begin
    logic [cfg_menu_pkg::NB-1:0] pressed;
    logic [cfg_menu_pkg::NB-1:0] press;
    logic single;
    logic combo;
    logic up;
    logic dn;
    logic sel;
    logic ent;
    logic [cfg_menu_pkg::N_IRQ-1:0] ev;
    logic [cfg_menu_pkg::N_IRQ-1:0] clr;
    logic [cfg_menu_pkg::N_ALM-1:0] valid;
    logic [31:0] rd;
    logic [7:0] adr;
    logic [3:0] subs;
    logic [3:0] digs;
    logic back_up;
    logic [31:0] wm;
    pressed = ~flt[cfg_menu_pkg::NB-1:0];
    press = pressed & ~q.prev;
    single = 1'b0;
    combo = 1'b0;
    ev = '0;
    clr = '0;
    rd = '0;
    wm = '0;
    adr = {wb_adr_i[7:2], 2'b00};
    subs = q.menu_cfg[cfg_menu_pkg::F_SUB +: 4];
    digs = q.menu_cfg[cfg_menu_pkg::F_DIGS +: 4];
    back_up = (subs == 4'h1);
    next_q = q;
    next_q.ack = 1'b0;
    next_q.prev = pressed;
    next_q.bus_ok = flt[cfg_menu_pkg::NB];
    kick = |press;

    // Actions need all buttons released since the last one
    if (pressed == '0) begin
      next_q.armed = 1'b1;
    end
    combo = q.armed && pressed[cfg_menu_pkg::BTN_SEL] && pressed[cfg_menu_pkg::BTN_ENT];
    single = q.armed && !combo && press != '0 && pressed == press && $onehot(press);
    if (combo || single) begin
      next_q.armed = 1'b0;
    end
    up = single && press[cfg_menu_pkg::BTN_UP];
    dn = single && press[cfg_menu_pkg::BTN_DN];
    sel = single && press[cfg_menu_pkg::BTN_SEL];
    ent = single && press[cfg_menu_pkg::BTN_ENT];

    unique case (q.st)
      cfg_menu_pkg::ST_OPER: begin
        if (combo) begin
          ev[cfg_menu_pkg::IRQ_ENTER] = 1'b1;
          next_q.hl = '0;
          next_q.code = '0;
          next_q.pos = '0;
          next_q.st = (q.acode == cfg_menu_pkg::DEF_CODE) ? cfg_menu_pkg::ST_MAIN
                                                           : cfg_menu_pkg::ST_CODE;
        end else if (up || dn) begin
          next_q.screen = wrap_step(q.screen, q.cfg1[cfg_menu_pkg::F_LAST +: 4], up);
        end
      end
      cfg_menu_pkg::ST_CODE: begin
        if (up || dn) begin
          next_q.code = 16'(step_nib({16'h0000, q.code}, q.pos, up));
        end else if (sel) begin
          next_q.pos = next_pos(q.pos, 4'(cfg_menu_pkg::CODE_DIGS));
        end else if (ent) begin
          next_q.pos = '0;
          if (q.code == q.acode) begin
            next_q.st = cfg_menu_pkg::ST_MAIN;
          end else begin
            next_q.st = cfg_menu_pkg::ST_BAD;
            ev[cfg_menu_pkg::IRQ_BADCODE] = 1'b1;
          end
        end
      end
      cfg_menu_pkg::ST_BAD: begin
        if (single) begin
          next_q.st = cfg_menu_pkg::ST_OPER;
          ev[cfg_menu_pkg::IRQ_EXIT] = 1'b1;
        end
      end
      cfg_menu_pkg::ST_MAIN: begin
        if (up || dn) begin
          next_q.hl = wrap_step(q.hl, q.menu_cfg[cfg_menu_pkg::F_MAIN +: 4], up);
        end else if (sel) begin
          next_q.sub_hl = '0;
          next_q.st = cfg_menu_pkg::ST_SUB;
        end else if (ent) begin
          next_q.st = cfg_menu_pkg::ST_OPER;
          ev[cfg_menu_pkg::IRQ_EXIT] = 1'b1;
        end
      end
      cfg_menu_pkg::ST_SUB: begin
        if (up || dn) begin
          next_q.sub_hl = wrap_step(q.sub_hl, subs, up);
        end else if (sel) begin
          next_q.pos = '0;
          if (q.menu_cfg[cfg_menu_pkg::F_MULTI + 32'(q.sub_hl[2:0])]) begin
            next_q.st = cfg_menu_pkg::ST_DIG;
          end else begin
            next_q.st = cfg_menu_pkg::ST_ADJ;
          end
        end else if (ent) begin
          next_q.st = cfg_menu_pkg::ST_MAIN;
        end
      end
      cfg_menu_pkg::ST_ADJ: begin
        if (up || dn) begin
          next_q.val[3:0] = wrap_step(q.val[3:0], q.menu_cfg[cfg_menu_pkg::F_OPTS +: 4], up);
        end else if (ent) begin
          ev[cfg_menu_pkg::IRQ_COMMIT] = 1'b1;
          next_q.st = back_up ? cfg_menu_pkg::ST_MAIN : cfg_menu_pkg::ST_SUB;
        end
      end
      cfg_menu_pkg::ST_DIG: begin
        if (up || dn) begin
          next_q.val = step_nib(q.val, q.pos, up);
        end else if (sel) begin
          next_q.pos = next_pos(q.pos, digs);
        end else if (ent) begin
          ev[cfg_menu_pkg::IRQ_COMMIT] = 1'b1;
          next_q.pos = '0;
          next_q.st = back_up ? cfg_menu_pkg::ST_MAIN : cfg_menu_pkg::ST_SUB;
        end
      end
      default: begin
        next_q.st = cfg_menu_pkg::ST_OPER;
      end
    endcase

    if (tmo) begin
      next_q.st = cfg_menu_pkg::ST_OPER;
      next_q.pos = '0;
      ev[cfg_menu_pkg::IRQ_TIMEOUT] = 1'b1;
    end
    if (q.bus_ok && !flt[cfg_menu_pkg::NB]) begin
      ev[cfg_menu_pkg::IRQ_PWR] = 1'b1;
    end

    // Register read mux
    case (adr)
      cfg_menu_pkg::REG_STATUS: begin
        rd[6:0] = q.st;
        rd[cfg_menu_pkg::S_HL +: 4] = q.hl;
        rd[cfg_menu_pkg::S_SUB +: 4] = q.sub_hl;
        rd[cfg_menu_pkg::S_POS +: 3] = q.pos;
        rd[cfg_menu_pkg::S_BUS] = q.bus_ok;
        rd[cfg_menu_pkg::S_FLASH] = flash;
      end
      cfg_menu_pkg::REG_IRQ_STAT: rd[cfg_menu_pkg::N_IRQ-1:0] = q.irq_stat;
      cfg_menu_pkg::REG_IRQ_MASK: rd[cfg_menu_pkg::N_IRQ-1:0] = q.irq_mask;
      cfg_menu_pkg::REG_ACODE: rd[15:0] = q.acode;
      cfg_menu_pkg::REG_CFG0: rd = q.cfg0;
      cfg_menu_pkg::REG_QCODE: rd[15:0] = q.qcode;
      cfg_menu_pkg::REG_CFG1: rd = q.cfg1;
      cfg_menu_pkg::REG_BAR: rd = q.bar;
      cfg_menu_pkg::REG_SCALE: rd = q.scale;
      cfg_menu_pkg::REG_MENU: rd = q.menu_cfg;
      cfg_menu_pkg::REG_EDIT: rd = q.val;
      default: rd = '0;
    endcase

    // Wishbone classic cycle, one wait state
    if (wb_cyc_i && wb_stb_i && !q.ack) begin
      next_q.ack = 1'b1;
      next_q.dat = rd;
      if (wb_we_i) begin
        case (adr)
          cfg_menu_pkg::REG_IRQ_STAT: begin
            wm = merge('0, wb_dat_i, wb_sel_i);
            clr = wm[cfg_menu_pkg::N_IRQ-1:0];
          end
          cfg_menu_pkg::REG_IRQ_MASK: begin
            wm = merge(32'(q.irq_mask), wb_dat_i, wb_sel_i);
            next_q.irq_mask = wm[cfg_menu_pkg::N_IRQ-1:0];
          end
          cfg_menu_pkg::REG_ACODE: begin
            wm = merge(32'(q.acode), wb_dat_i, wb_sel_i);
            next_q.acode = wm[15:0];
          end
          cfg_menu_pkg::REG_CFG0: next_q.cfg0 = merge(q.cfg0, wb_dat_i, wb_sel_i);
          cfg_menu_pkg::REG_QCODE: begin
            wm = merge(32'(q.qcode), wb_dat_i, wb_sel_i);
            next_q.qcode = wm[15:0];
          end
          cfg_menu_pkg::REG_CFG1: next_q.cfg1 = merge(q.cfg1, wb_dat_i, wb_sel_i);
          cfg_menu_pkg::REG_BAR: next_q.bar = merge(q.bar, wb_dat_i, wb_sel_i);
          cfg_menu_pkg::REG_SCALE: next_q.scale = merge(q.scale, wb_dat_i, wb_sel_i);
          cfg_menu_pkg::REG_MENU: next_q.menu_cfg = merge(q.menu_cfg, wb_dat_i, wb_sel_i);
          cfg_menu_pkg::REG_EDIT: next_q.val = merge(q.val, wb_dat_i, wb_sel_i);
          cfg_menu_pkg::REG_DEFAULTS: begin
            if (wb_sel_i[0] && wb_dat_i[0]) begin
              next_q.acode = cfg_menu_pkg::DEF_CODE;
              next_q.qcode = cfg_menu_pkg::DEF_CODE;
              next_q.cfg0 = cfg_menu_pkg::DEF_CFG0;
              next_q.cfg1 = cfg_menu_pkg::DEF_CFG1;
              next_q.bar = cfg_menu_pkg::DEF_BAR;
              next_q.scale = cfg_menu_pkg::DEF_SCALE;
            end
          end
          default: begin
          end
        endcase
      end
    end

    // Set wins over a same-cycle clear
    next_q.irq_stat = (q.irq_stat & ~clr) | ev;
    next_q.irq = |(next_q.irq_stat & next_q.irq_mask);

    // Alarm switches open without bus power
    valid = q.cfg1[cfg_menu_pkg::F_GOOD] ? {cfg_menu_pkg::N_ALM{data_good}} : '1;
    next_q.alm = {cfg_menu_pkg::N_ALM{flt[cfg_menu_pkg::NB]}}
      & ((alarm_req & q.cfg1[cfg_menu_pkg::F_ALM_EN +: cfg_menu_pkg::N_ALM] & valid)
         ^ q.cfg1[cfg_menu_pkg::F_NC +: cfg_menu_pkg::N_ALM]);
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
      q.st <= cfg_menu_pkg::ST_OPER;
      q.bus_ok <= 1'b1;
      q.acode <= cfg_menu_pkg::DEF_CODE;
      q.qcode <= cfg_menu_pkg::DEF_CODE;
      q.cfg0 <= cfg_menu_pkg::DEF_CFG0;
      q.cfg1 <= cfg_menu_pkg::DEF_CFG1;
      q.bar <= cfg_menu_pkg::DEF_BAR;
      q.scale <= cfg_menu_pkg::DEF_SCALE;
      q.menu_cfg <= cfg_menu_pkg::DEF_MENU;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign wb_ack_o = q.ack;
  assign wb_dat_o = q.dat;
  assign alarm_close = q.alm;
  assign irq = q.irq;
  assign menu_state = q.st;
  assign highlight = q.hl;
  assign sub_highlight = q.sub_hl;
  assign edit_pos = q.pos;
  assign edit_value = q.val;
  assign flash = (q.st == cfg_menu_pkg::ST_CODE) || (q.st == cfg_menu_pkg::ST_ADJ)
                 || (q.st == cfg_menu_pkg::ST_DIG);
  assign screen_sel = q.screen;
endmodule
`default_nettype wire

// [design/idle_timer.sv]
// Inactivity timer with restart and selectable limit
`timescale 1ns/10ps
`default_nettype none
module idle_timer (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Control
  input wire logic run,
  input wire logic kick,
  input wire logic [31:0] limit,
  output logic expired
);
  typedef struct packed {
    logic [31:0] cnt;
    logic exp;
  } tmr_s;

  tmr_s q;
  tmr_s next_q;

  always_comb begin
    next_q = q;
    next_q.exp = 1'b0;
    if (!run || kick) begin
      next_q.cnt = '0;
    end else if (q.cnt >= limit - 32'h0000_0001) begin
      next_q.cnt = '0;
      next_q.exp = 1'b1;
    end else begin
      next_q.cnt = q.cnt + 32'h0000_0001;
    end
  end

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      q <= '0;
    end else if (ce) begin
      q <= next_q;
    end
  end

  assign expired = q.exp;
endmodule
`default_nettype wire

// [sim/front_panel_menu_asserts.sv]
// Port assertions for the front-panel menu controller
`timescale 1ns/10ps
`default_nettype none
module front_panel_menu_asserts #(
  parameter logic [31:0] CODE_TO = 32'h0000_00C8,
  parameter logic [31:0] MENU_TO = 32'h0000_01F4,
  parameter logic [31:0] DEB_HOLD = 32'h0000_0004
) (
  // Clock and reset
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic ce,
  // Bus handshake
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  // Pins and menu view
  input wire logic [3:0] btn_n,
  input wire logic bus_power_ok,
  input wire logic [5:0] alarm_close,
  input wire logic [6:0] menu_state,
  input wire logic flash
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  // Cycles since any button pin was last low, and since power went away
  logic [31:0] quiet;
  logic [31:0] dark;
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      quiet <= 32'h0000_0000;
      dark <= 32'h0000_0000;
    end else begin
      quiet <= (btn_n != 4'hF) ? 32'h0000_0000 : quiet + 1;
      dark <= bus_power_ok ? 32'h0000_0000 : dark + 1;
    end
  end
  property p_ack_due; wb_cyc_i && wb_stb_i && !wb_ack_o && ce |=> wb_ack_o; endproperty
  a_ack_due: assert property (p_ack_due) else $error("request not acknowledged");
  property p_flash; flash == |(menu_state & 7'h62); endproperty
  a_flash: assert property (p_flash) else $error("flash wrong for state");
  property p_oper_exit; (menu_state == 7'h01) ##1 (menu_state != 7'h01) |->
    (menu_state == 7'h02 || menu_state == 7'h08); endproperty
  a_oper_exit: assert property (p_oper_exit) else $error("bad menu entry state");
  property p_entry_keys; (menu_state == 7'h01) ##1 (menu_state != 7'h01) |->
    ($past(btn_n, 5) & 4'h3) == 4'h0; endproperty
  a_entry_keys: assert property (p_entry_keys) else $error("entry without both keys");
  property p_code_exit; (menu_state == 7'h02) ##1 (menu_state != 7'h02) |->
    (menu_state == 7'h01 || menu_state == 7'h04 || menu_state == 7'h08); endproperty
  a_code_exit: assert property (p_code_exit) else $error("bad exit from code");
  property p_main_exit; (menu_state == 7'h08) ##1 (menu_state != 7'h08) |->
    (menu_state == 7'h01 || menu_state == 7'h10); endproperty
  a_main_exit: assert property (p_main_exit) else $error("bad exit from main");
  property p_code_to; menu_state == 7'h02 |-> quiet <= CODE_TO + DEB_HOLD + 8; endproperty
  a_code_to: assert property (p_code_to) else $error("code entry outlived timeout");
  property p_menu_to; quiet > MENU_TO + DEB_HOLD + 8 |-> menu_state == 7'h01; endproperty
  a_menu_to: assert property (p_menu_to) else $error("menu outlived timeout");
  property p_power; dark > DEB_HOLD + 8 |-> alarm_close == 6'h00; endproperty
  a_power: assert property (p_power) else $error("alarm closed without power");
endmodule
bind front_panel_menu front_panel_menu_asserts #(.CODE_TO(CODE_TO), .MENU_TO(MENU_TO),
  .DEB_HOLD(DEB_HOLD)) u_chk (.clk_sys, .rst, .ce, .wb_cyc_i, .wb_stb_i, .wb_ack_o,
  .btn_n, .bus_power_ok, .alarm_close, .menu_state, .flash);
`default_nettype wire

// [sim/panel_operator.sv]
// Operator model driving the four front-panel buttons
`timescale 1ns/10ps
`default_nettype none
module panel_operator (
  // Clock
  input wire logic clk_sys,
  // Buttons, active low
  output logic [3:0] btn_n
);
  initial btn_n = 4'hF;
  // Hold past the screen change, then release all
  task automatic press(input logic [3:0] keys);
    @(posedge clk_sys);
    btn_n <= ~keys;
    repeat (16) @(posedge clk_sys);
    btn_n <= 4'hF;
    repeat (16) @(posedge clk_sys);
  endtask
endmodule
`default_nettype wire

// [sim/testbench.sv]
// Self-checking bench for the front-panel menu controller
`timescale 1ns/10ps
`default_nettype none
module testbench;
  localparam logic [3:0] K_SEL = 4'h1;
  localparam logic [3:0] K_ENT = 4'h2;
  localparam logic [3:0] K_UP = 4'h8;
  localparam logic [3:0] K_DN = 4'h4;
  localparam logic [3:0] K_PE = 4'h3;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1;
  logic cyc = 1'b0;
  logic we = 1'b0;
  logic [7:0] adr = 8'h00;
  logic [31:0] wdat = 32'h0000_0000;
  logic pwr = 1'b1;
  logic good = 1'b1;
  logic [5:0] areq = 6'h00;
  logic [31:0] rdat, got, ev;
  logic [3:0] btn_n, hl, shl, scr;
  logic [6:0] state;
  logic [5:0] alm;
  logic [2:0] pos;
  logic ack, irq, flash;
  int mismatches = 0;
  int n_compared = 0;
  logic [31:0] defs [10] = '{32'h0000_0000,
    {5'h00, 2'h3, 2'h2, 7'h32, 1'h0, 7'h64, 1'h0, 7'h7E}, 32'h0000_0000,
    {4'h8, 4'h1, 1'h0, 6'h3F, 1'h1, 16'h0001}, 32'h0064_0000, 32'h0001_0000,
    32'h0000_0000, 32'h0042_001B, 32'h0000_0000, 32'h0000_0000};
  always #12.5 clk_sys = ~clk_sys;
  front_panel_menu #(.CODE_TO(32'h0000_00C8), .MENU_TO(32'h0000_01F4),
    .DEB_HOLD(32'h0000_0004)) i_front_panel_menu (.clk_sys, .rst, .ce,
    .wb_cyc_i(cyc), .wb_stb_i(cyc), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF),
    .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .btn_n, .bus_power_ok(pwr),
    .alarm_req(areq), .data_good(good), .alarm_close(alm), .irq, .menu_state(state),
    .highlight(hl), .sub_highlight(shl), .edit_pos(pos), .edit_value(ev), .flash,
    .screen_sel(scr));
  panel_operator op (.clk_sys, .btn_n);
  task automatic wrap_up();
    if (mismatches == 0 && n_compared > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge clk_sys);
    cyc <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge clk_sys);
      n++;
    end while (ack !== 1'b1 && n < 50);
    if (ack !== 1'b1) mismatches++;
    got = rdat;
    cyc <= 1'b0;
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    wb(1'b0, a, 32'h0000_0000);
    check(got, exp);
  endtask
  task automatic go(input logic [3:0] k, input logic [6:0] s);
    op.press(k);
    check(32'(state), 32'(s));
  endtask
  task automatic hold(input int n, input logic [6:0] s);
    repeat (n) @(posedge clk_sys);
    check(32'(state), 32'(s));
  endtask
  initial begin
    repeat (10000) @(posedge clk_sys);
    mismatches++;
    wrap_up();
  end
  initial begin
    repeat (16) @(posedge clk_sys);
    rst <= 1'b0;
    for (int i = 0; i < 10; i++) rd(8'(12 + 4 * i), defs[i]);
    wb(1'b1, cfg_menu_pkg::REG_STATUS, 32'hFFFF_FFFF);
    rd(cfg_menu_pkg::REG_STATUS, 32'h0010_0001);
    check(32'(alm), 32'h0000_003F);
    wb(1'b1, cfg_menu_pkg::REG_CFG0, 32'h0000_0000);
    wb(1'b1, cfg_menu_pkg::REG_DEFAULTS, 32'h0000_0001);
    rd(cfg_menu_pkg::REG_CFG0, defs[1]);
    wb(1'b1, cfg_menu_pkg::REG_IRQ_MASK, 32'h0000_0001);
    go(K_PE, cfg_menu_pkg::ST_MAIN);
    check(32'(irq), 32'h0000_0001);
    wb(1'b1, cfg_menu_pkg::REG_IRQ_STAT, 32'h0000_003F);
    check(32'(irq), 32'h0000_0000);
    go(K_UP, cfg_menu_pkg::ST_MAIN);
    check(32'(hl), 32'h0000_0001);
    go(K_SEL, cfg_menu_pkg::ST_SUB);
    go(K_SEL, cfg_menu_pkg::ST_ADJ);
    go(K_UP, cfg_menu_pkg::ST_ADJ);
    check(32'(ev[3:0]), 32'h0000_0001);
    go(K_ENT, cfg_menu_pkg::ST_MAIN);
    rd(cfg_menu_pkg::REG_IRQ_STAT, 32'h0000_0008);
    go(K_ENT, cfg_menu_pkg::ST_OPER);
    wb(1'b1, cfg_menu_pkg::REG_MENU, 32'h0042_0122);
    wb(1'b1, cfg_menu_pkg::REG_EDIT, 32'h0000_0000);
    go(K_PE, cfg_menu_pkg::ST_MAIN);
    go(K_SEL, cfg_menu_pkg::ST_SUB);
    go(K_SEL, cfg_menu_pkg::ST_DIG);
    go(K_UP, cfg_menu_pkg::ST_DIG);
    go(K_SEL, cfg_menu_pkg::ST_DIG);
    check(32'(pos), 32'h0000_0001);
    go(K_UP, cfg_menu_pkg::ST_DIG);
    check(ev, 32'h0000_0011);
    go(K_ENT, cfg_menu_pkg::ST_SUB);
    go(K_UP, cfg_menu_pkg::ST_SUB);
    check(32'(shl), 32'h0000_0001);
    go(K_SEL, cfg_menu_pkg::ST_ADJ);
    go(K_ENT, cfg_menu_pkg::ST_SUB);
    hold(400, cfg_menu_pkg::ST_SUB);
    go(K_UP, cfg_menu_pkg::ST_SUB);
    hold(400, cfg_menu_pkg::ST_SUB);
    hold(200, cfg_menu_pkg::ST_OPER);
    go(K_DN, cfg_menu_pkg::ST_OPER);
    check(32'(scr), 32'h0000_0007);
    wb(1'b1, cfg_menu_pkg::REG_ACODE, 32'h0000_0012);
    go(K_PE, cfg_menu_pkg::ST_CODE);
    check(32'(flash), 32'h0000_0001);
    go(K_UP, cfg_menu_pkg::ST_CODE);
    go(K_UP, cfg_menu_pkg::ST_CODE);
    go(K_SEL, cfg_menu_pkg::ST_CODE);
    go(K_UP, cfg_menu_pkg::ST_CODE);
    go(K_ENT, cfg_menu_pkg::ST_MAIN);
    go(K_ENT, cfg_menu_pkg::ST_OPER);
    wb(1'b1, cfg_menu_pkg::REG_IRQ_MASK, 32'h0000_0002);
    wb(1'b1, cfg_menu_pkg::REG_IRQ_STAT, 32'h0000_003F);
    go(K_PE, cfg_menu_pkg::ST_CODE);
    check(32'(irq), 32'h0000_0000);
    go(K_ENT, cfg_menu_pkg::ST_BAD);
    check(32'(irq), 32'h0000_0001);
    go(K_UP, cfg_menu_pkg::ST_OPER);
    go(K_PE, cfg_menu_pkg::ST_CODE);
    hold(150, cfg_menu_pkg::ST_CODE);
    hold(100, cfg_menu_pkg::ST_OPER);
    wb(1'b1, cfg_menu_pkg::REG_CFG1, defs[3] | 32'h0000_0100);
    areq <= 6'h01;
    repeat (4) @(posedge clk_sys);
    check(32'(alm), 32'h0000_003E);
    good <= 1'b0;
    repeat (4) @(posedge clk_sys);
    check(32'(alm), 32'h0000_003F);
    pwr <= 1'b0;
    repeat (20) @(posedge clk_sys);
    check(32'(alm), 32'h0000_0000);
    rd(cfg_menu_pkg::REG_IRQ_STAT, 32'h0000_0037);
    ce <= 1'b0;
    pwr <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check(32'(alm), 32'h0000_0000);
    ce <= 1'b1;
    repeat (20) @(posedge clk_sys);
    check(32'(alm), 32'h0000_003F);
    wrap_up();
  end
endmodule
`default_nettype wire
